// ==== logic/fepd_flash.sv ====
// Flash end: decodes erase, write unlock, power-down and wake frames.
// Assumes the link pins are asynchronous and sampled here; the serial
// clock is far slower than CLK_I. The erase itself is reported as a pulse.
`timescale 1ns/100ps
`default_nettype none
module fepd_flash
  import fepd_pkg::*;
#(
  parameter int SMALL_CYC = SMALL_WIPE_CYC,
  parameter int HALF_CYC = HALF_WIPE_CYC,
  parameter int FULL_CYC = FULL_WIPE_CYC,
  parameter longint ARRAY_CYC = ARRAY_WIPE_CYC
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  fepd_link_if.dev LINK,
  input wire logic [3:0] PROTECT_I,
  input wire logic EXT_BUSY_I,
  output logic BUSY_O,
  output logic UNLOCK_O,
  output logic POWER_DOWN_O,
  output logic QUAD_O,
  output logic WIPE_START_O,
  output fepd_pkg::fepd_wipe_t WIPE_KIND_O,
  output logic [23:0] WIPE_BASE_O
);
  import fepd_pkg::*;

  logic [5:0] pins_s;
  logic cs_n_s, sck_s;
  logic [3:0] dq_s;
  logic sck_d_reg, cs_n_d_reg;
  logic [31:0] shift_reg;
  logic [5:0] cnt_reg;
  logic [36:0] timer_reg; // Wide enough for a full-rate whole-array wipe
  logic pd_pend_reg;
  logic wake_pend_reg;
  logic [15:0] pd_cnt_reg;
  wire pd_timer_done = pd_cnt_reg == 16'h0000;

  fepd_sync #(.W(6)) u_sync (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .d_i({LINK.cs_n, LINK.sck, LINK.dq}),
    .q_o(pins_s)
  );
  assign cs_n_s = pins_s[5];
  assign sck_s = pins_s[4];
  assign dq_s = pins_s[3:0];

  // The flash never answers on the data lines in this command set
  assign LINK.dev_dq_o = 4'h0;
  assign LINK.dev_dq_oe = 4'h0;

  // Edge detection on synchronised pins
  wire sck_rise = sck_s && !sck_d_reg && !cs_n_s;
  wire cs_rise = cs_n_s && !cs_n_d_reg;
  // Bits per clock follow the line mode
  wire [31:0] shift_next = QUAD_O ? {shift_reg[27:0], dq_s} : {shift_reg[30:0], dq_s[0]};
  wire [5:0] op_len = QUAD_O ? OPCODE_NIBS : OPCODE_BITS;
  wire [5:0] adr_len = QUAD_O ? ADDR_FRAME_NIBS : ADDR_FRAME_BITS;
  wire op_frame = cnt_reg == op_len;
  wire adr_frame = cnt_reg == adr_len;
  wire [7:0] op_short = shift_reg[7:0];
  wire [7:0] op_long = shift_reg[31:24];
  wire [23:0] adr = shift_reg[23:0];
  wire running = BUSY_O || EXT_BUSY_I;

  // Command opcode decode: region and array erases, unlock, power modes, four-line entry
  wire is_small = adr_frame && op_long == OP_SMALL_WIPE;
  wire is_half = adr_frame && op_long == OP_HALF_WIPE;
  wire is_full = adr_frame && op_long == OP_FULL_WIPE;
  wire is_array = op_frame && (op_short == OP_ARRAY_WIPE_A || op_short == OP_ARRAY_WIPE_B);
  wire is_unlock = op_frame && op_short == OP_WRITE_UNLOCK;
  wire is_lowpwr = op_frame && op_short == OP_LOW_POWER;
  wire is_wake = op_frame && op_short == OP_WAKE;
  wire is_quad = op_frame && op_short == OP_QUAD_ENTRY;

  // Region base from the address field
  wire [23:0] base_small = {adr[23:SECTOR_LSB], 12'h000};
  wire [23:0] base_half = {adr[23:HALF_LSB], 15'h0000};
  wire [23:0] base_full = {adr[23:BLOCK_LSB], 16'h0000};
  wire [23:0] base_sel = is_small ? base_small : (is_half ? base_half : base_full);

  // Protected area grows downward from the top: level n shields top 2^(n-1) 64KB blocks, all 16 from level 5 up
  wire [4:0] prot_blocks = (PROTECT_I == 4'h0) ? 5'h00 :
                           ((PROTECT_I >= 4'h5) ? 5'h10 : 5'(5'h01 << (PROTECT_I - 4'h1)));
  wire [4:0] blk_idx = {1'b0, base_sel[19:16]};
  wire in_prot = (5'h10 - blk_idx) <= prot_blocks;

  // Acceptance: live chip, unlocked, nothing running
  wire may_erase = !POWER_DOWN_O && !pd_pend_reg && !wake_pend_reg && UNLOCK_O && !running;
  wire take_region = cs_rise && (is_small || is_half || is_full) && may_erase && !in_prot;
  wire take_array = cs_rise && is_array && may_erase && PROTECT_I == 4'h0;
  wire take_any = take_region || take_array;
  wire live = !POWER_DOWN_O && !pd_pend_reg && !wake_pend_reg && !running;
  wire take_unlock = cs_rise && is_unlock && live;
  wire take_lowpwr = cs_rise && is_lowpwr && live;
  wire take_wake = cs_rise && is_wake && POWER_DOWN_O && !wake_pend_reg;
  wire take_quad = cs_rise && is_quad && live;
  fepd_wipe_t kind_sel;
  assign kind_sel = is_array ? WIPE_ARRAY : (is_small ? WIPE_SMALL :
                    (is_half ? WIPE_HALF : WIPE_FULL));
  wire [36:0] dur_sel = is_array ? 37'(ARRAY_CYC) : (is_small ? 37'(SMALL_CYC) :
                        (is_half ? 37'(HALF_CYC) : 37'(FULL_CYC)));

  // Serial shifter, bit count cleared while deselected so a new frame starts clean
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sck_d_reg <= 1'b1; // Matches the synchroniser's reset level, so no false edge
      cs_n_d_reg <= 1'b1;
      shift_reg <= 32'h00000000;
      cnt_reg <= 6'h00;
    end else begin
      sck_d_reg <= sck_s;
      cs_n_d_reg <= cs_n_s;
      if (cs_n_s && !cs_rise) begin
        cnt_reg <= 6'h00;
      end else if (sck_rise) begin
        shift_reg <= shift_next;
        cnt_reg <= (cnt_reg == 6'h3F) ? cnt_reg : cnt_reg + 6'h01; // Saturate on overlong frames
      end
    end
  end

  // Self-timed cycle; unlock flag drops when the cycle ends
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      BUSY_O <= 1'b0;
      UNLOCK_O <= 1'b0;
      timer_reg <= 37'h0000000000;
      WIPE_START_O <= 1'b0;
      WIPE_KIND_O <= WIPE_NONE;
      WIPE_BASE_O <= 24'h000000;
    end else begin
      WIPE_START_O <= take_any;
      if (take_any) begin
        BUSY_O <= 1'b1;
        timer_reg <= dur_sel;
        WIPE_KIND_O <= kind_sel;
        WIPE_BASE_O <= is_array ? 24'h000000 : base_sel;
      end else if (BUSY_O) begin
        timer_reg <= timer_reg - 37'h0000000001;
        if (timer_reg <= 37'h0000000001) begin
          BUSY_O <= 1'b0;
          UNLOCK_O <= 1'b0;
        end
      end
      if (take_unlock) begin
        UNLOCK_O <= 1'b1;
      end
    end
  end

  // Power modes; reset always lands in standby with line mode single
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      POWER_DOWN_O <= 1'b0;
      pd_pend_reg <= 1'b0;
      wake_pend_reg <= 1'b0;
      QUAD_O <= 1'b0;
    end else begin
      if (take_quad) begin
        QUAD_O <= 1'b1;
      end
      if (take_lowpwr) begin
        pd_pend_reg <= 1'b1;
      end else if (pd_pend_reg) begin
        if (pd_timer_done) begin
          pd_pend_reg <= 1'b0;
          POWER_DOWN_O <= 1'b1;
        end
      end
      if (take_wake) begin
        wake_pend_reg <= 1'b1;
      end else if (wake_pend_reg && pd_timer_done) begin
        wake_pend_reg <= 1'b0;
        POWER_DOWN_O <= 1'b0;
      end
    end
  end

  // Entry and wake delays share one small counter; they never overlap
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      pd_cnt_reg <= 16'h0000;
    end else if (take_lowpwr) begin
      pd_cnt_reg <= 16'(PD_ENTRY_CYC);
    end else if (take_wake) begin
      pd_cnt_reg <= 16'(WAKE_CYC);
    end else if (!pd_timer_done) begin
      pd_cnt_reg <= pd_cnt_reg - 16'h0001;
    end
  end
endmodule // fepd_flash
`default_nettype wire

// ==== logic/fepd_host.sv ====
// Host end: frames one command per request on the serial link.
// Assumes the flash end samples the link with its own clock.
`timescale 1ns/100ps
`default_nettype none
module fepd_host
  import fepd_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  fepd_link_if.host LINK,
  input wire logic REQ_I,
  input wire logic [7:0] OPCODE_I,
  input wire logic [23:0] ADDR_I,
  input wire logic QUAD_I,
  output logic READY_O,
  output logic DONE_O
);
  import fepd_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SHIFT = 2'b01,
    H_GAP = 2'b10
  } fepd_hst_t;

  fepd_hst_t st_reg;
  logic [31:0] data_reg;
  logic [5:0] left_reg;
  logic [7:0] div_reg;
  logic quad_reg;
  logic cs_n_reg, sck_reg;

  // Region erases carry an address; all others are opcode only
  wire has_adr = OPCODE_I == OP_SMALL_WIPE || OPCODE_I == OP_HALF_WIPE ||
                 OPCODE_I == OP_FULL_WIPE;
  wire [5:0] len_sel = has_adr ? (QUAD_I ? ADDR_FRAME_NIBS : ADDR_FRAME_BITS) :
                       (QUAD_I ? OPCODE_NIBS : OPCODE_BITS);
  wire [31:0] data_sel = has_adr ? {OPCODE_I, ADDR_I} : {OPCODE_I, 24'h000000};
  wire div_end = div_reg == 8'(SCK_HALF_CYC - 1);
  // Gap covers the wake delay with margin
  wire [7:0] gap_len = 8'(WAKE_CYC + 2 * SCK_HALF_CYC);

  assign LINK.cs_n = cs_n_reg;
  assign LINK.sck = sck_reg;
  assign LINK.host_dq_o = quad_reg ? data_reg[31:28] : {3'b000, data_reg[31]};
  assign LINK.host_dq_oe = cs_n_reg ? 4'h0 : (quad_reg ? 4'hF : 4'h1);

  // Serial clock made by dividing CLK_I; select held low for the whole frame
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      st_reg <= H_IDLE;
      data_reg <= 32'h00000000;
      left_reg <= 6'h00;
      div_reg <= 8'h00;
      quad_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      sck_reg <= 1'b0;
      READY_O <= 1'b0;
      DONE_O <= 1'b0;
    end else begin
      DONE_O <= 1'b0;
      case (st_reg)
        H_IDLE: begin
          READY_O <= 1'b1;
          if (REQ_I && READY_O) begin
            READY_O <= 1'b0;
            data_reg <= data_sel;
            left_reg <= len_sel;
            quad_reg <= QUAD_I;
            cs_n_reg <= 1'b0;
            div_reg <= 8'h00;
            st_reg <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          div_reg <= div_end ? 8'h00 : div_reg + 8'h01;
          if (div_end) begin
            if (!sck_reg) begin
              sck_reg <= 1'b1;
              left_reg <= left_reg - 6'h01;
            end else begin
              sck_reg <= 1'b0;
              data_reg <= quad_reg ? {data_reg[27:0], 4'h0} : {data_reg[30:0], 1'b0};
              if (left_reg == 6'h00) begin
                cs_n_reg <= 1'b1;
                st_reg <= H_GAP;
              end
            end
          end
        end
        H_GAP: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == gap_len) begin
            DONE_O <= 1'b1;
            st_reg <= H_IDLE;
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end
endmodule // fepd_host
`default_nettype wire

// ==== logic/fepd_link_if.sv ====
// Serial link between the host end and the flash end.
// Four data lines; each end drives a line only while its enable is high.
`timescale 1ns/100ps
`default_nettype none
interface fepd_link_if;
  logic cs_n;
  logic sck;
  logic [3:0] host_dq_o;
  logic [3:0] host_dq_oe;
  logic [3:0] dev_dq_o;
  logic [3:0] dev_dq_oe;
  logic [3:0] dq;
  // Line level resolved from enables; an undriven line reads high
  genvar g;
  for (g = 0; g < 4; g++) begin : g_res
    assign dq[g] = host_dq_oe[g] ? host_dq_o[g] : (dev_dq_oe[g] ? dev_dq_o[g] : 1'b1);
  end
  modport host (output cs_n, output sck, output host_dq_o, output host_dq_oe, input dq);
  modport dev (input cs_n, input sck, output dev_dq_o, output dev_dq_oe, input dq);
endinterface
`default_nettype wire

// ==== logic/fepd_pkg.sv ====
// Package for the flash erase and power-down command path.
// Shared by the flash end, the host end, the checker and the bench; assumes a 25 MHz clock.
package fepd_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_SMALL_WIPE = 8'h20;
  localparam logic [7:0] OP_HALF_WIPE = 8'h52;
  localparam logic [7:0] OP_FULL_WIPE = 8'hD8;
  localparam logic [7:0] OP_ARRAY_WIPE_A = 8'hC7;
  localparam logic [7:0] OP_ARRAY_WIPE_B = 8'h60;
  localparam logic [7:0] OP_LOW_POWER = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  localparam logic [7:0] OP_QUAD_ENTRY = 8'h38;
  // Frame lengths in serial clocks (single line)
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] ADDR_FRAME_BITS = 6'h20;
  // Frame lengths in serial clocks (four line)
  localparam logic [5:0] OPCODE_NIBS = 6'h02;
  localparam logic [5:0] ADDR_FRAME_NIBS = 6'h08;
  // Address field boundaries of erase regions
  localparam int SECTOR_LSB = 12;
  localparam int HALF_LSB = 15;
  localparam int BLOCK_LSB = 16;
  // Clock rate and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SMALL_WIPE_TIME_US = 30_000;
  localparam int HALF_WIPE_TIME_US = 100_000;
  localparam int FULL_WIPE_TIME_US = 200_000;
  localparam int ARRAY_WIPE_TIME_US = 3_000_000;
  localparam int POWER_DOWN_ENTRY_DELAY_US = 3;
  localparam int WAKE_DELAY_US = 3;
  localparam int SMALL_WIPE_CYC = SMALL_WIPE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int HALF_WIPE_CYC = HALF_WIPE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int FULL_WIPE_CYC = FULL_WIPE_TIME_US * (CLK_HZ / 1_000_000);
  // Whole-array count fits 32 bits at this clock rate; kept as longint
  localparam longint ARRAY_WIPE_CYC = longint'(ARRAY_WIPE_TIME_US) * (CLK_HZ / 1_000_000);
  localparam int PD_ENTRY_CYC = (POWER_DOWN_ENTRY_DELAY_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int WAKE_CYC = (WAKE_DELAY_US * CLK_HZ + 999_999) / 1_000_000;
  // Host serial clock half period in system clocks
  localparam int SCK_HALF_CYC = 4;
  // Reset values
  localparam logic [3:0] PROTECT_RST = 4'h0;
  // Erase kinds
  typedef enum logic [2:0] {
    WIPE_NONE = 3'b000,
    WIPE_SMALL = 3'b001,
    WIPE_HALF = 3'b010,
    WIPE_FULL = 3'b011,
    WIPE_ARRAY = 3'b100
  } fepd_wipe_t;
endpackage

// ==== logic/fepd_sync.sv ====
// Two-stage synchroniser for link pins entering the system clock domain.
// Assumes the pins are asynchronous to CLK_I.
`timescale 1ns/100ps
`default_nettype none
module fepd_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  // First stage read only by the second
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_reg <= '1;
      q_o <= '1;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // fepd_sync
`default_nettype wire

// ==== test/fepd_checker.sv ====
// Concurrent checks on the link between the host end and the flash end.
// Fed with the interface signals and the flash end's status outputs.
`timescale 1ns/100ps
`default_nettype none
module fepd_checker (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] dev_dq_oe,
  input wire logic [3:0] PROTECT_I,
  input wire logic BUSY_O,
  input wire logic UNLOCK_O,
  input wire logic POWER_DOWN_O,
  input wire logic WIPE_START_O,
  input wire logic [2:0] WIPE_KIND_O,
  input wire logic [23:0] WIPE_BASE_O
);
  import fepd_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // Framing: clock rests between frames, flash end never drives the lines
  idle_clock_a: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  no_dev_drive_a: assert property (dev_dq_oe == 4'h0)
    else $error("flash end drives data lines");
  // Erase starts only after the select has risen and stayed high
  start_on_deselect_a: assert property (WIPE_START_O |-> cs_n && $past(cs_n, 2))
    else $error("erase started inside a frame");
  start_unlocked_a: assert property (WIPE_START_O |-> UNLOCK_O)
    else $error("erase started without unlock");
  start_busy_a: assert property (WIPE_START_O |-> ##[0:1] BUSY_O)
    else $error("busy missing after erase start");
  busy_end_a: assert property ($fell(BUSY_O) |-> !UNLOCK_O)
    else $error("unlock still set at cycle end");
  start_idle_a: assert property (WIPE_START_O |-> !$past(BUSY_O))
    else $error("erase started while busy");
  start_awake_a: assert property (POWER_DOWN_O |-> !WIPE_START_O)
    else $error("erase started in power-down");
  array_clear_a: assert property (WIPE_START_O && WIPE_KIND_O == WIPE_ARRAY |->
    PROTECT_I == 4'h0 && WIPE_BASE_O == 24'h000000) else $error("array wipe while protected");
  sector_base_a: assert property (WIPE_START_O && WIPE_KIND_O == WIPE_SMALL |->
    WIPE_BASE_O[11:0] == 12'h000) else $error("sector base not aligned");
  pd_idle_a: assert property ($rose(POWER_DOWN_O) |-> !BUSY_O)
    else $error("power-down entered during erase");
  pd_delay_a: assert property ($rose(POWER_DOWN_O) |-> cs_n && $past(cs_n, 8))
    else $error("power-down entered too soon");
  // Main scenarios reached
  cov_array_c: cover property (WIPE_START_O && WIPE_KIND_O == WIPE_ARRAY);
  cov_pd_in_c: cover property ($rose(POWER_DOWN_O));
  cov_pd_out_c: cover property ($fell(POWER_DOWN_O));
endmodule // fepd_checker
`default_nettype wire

// ==== test/flash_erase_powerdown_ctrl_test.sv ====
// Self-checking bench: host end and flash end joined on one link, plus a
// second flash end fed by a bit-level driver that breaks framing on purpose.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("mismatch at %0t: %s", $time, m); end end
module flash_erase_powerdown_ctrl_test;
  import fepd_pkg::*;
  logic clk, nrst, req, quad, rdy, done, ext, busy, unl, pd, qd, ws, unl2, ws2;
  logic busy2, pd2, qd2;
  logic [7:0] opc;
  logic [23:0] adr, wb, last_b, a, wb2;
  logic [3:0] prot;
  fepd_wipe_t wk, last_k, wk2;
  logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
  int fails = 0, n_checks = 0, n_ws = 0, n_ws2 = 0, cyc = 0, i;
  fepd_link_if l1 ();
  fepd_link_if l2 ();
  fepd_host i_fepd_host (.CLK_I(clk), .NRST_I(nrst), .LINK(l1.host), .REQ_I(req),
    .OPCODE_I(opc), .ADDR_I(adr), .QUAD_I(quad), .READY_O(rdy), .DONE_O(done));
  // Short wipe counts keep each erase longer than one following frame
  fepd_flash #(.SMALL_CYC(300), .HALF_CYC(320), .FULL_CYC(340), .ARRAY_CYC(360)) i_fepd_flash (
    .CLK_I(clk), .NRST_I(nrst), .LINK(l1.dev), .PROTECT_I(prot), .EXT_BUSY_I(ext),
    .BUSY_O(busy), .UNLOCK_O(unl), .POWER_DOWN_O(pd), .QUAD_O(qd), .WIPE_START_O(ws),
    .WIPE_KIND_O(wk), .WIPE_BASE_O(wb));
  fepd_flash #(.SMALL_CYC(300), .HALF_CYC(320), .FULL_CYC(340), .ARRAY_CYC(360)) i_fepd_flash_2 (
    .CLK_I(clk), .NRST_I(nrst), .LINK(l2.dev), .PROTECT_I(prot), .EXT_BUSY_I(ext),
    .BUSY_O(busy2), .UNLOCK_O(unl2), .POWER_DOWN_O(pd2), .QUAD_O(qd2), .WIPE_START_O(ws2),
    .WIPE_KIND_O(wk2), .WIPE_BASE_O(wb2));
  fepd_checker i_fepd_checker (.CLK_I(clk), .NRST_I(nrst), .cs_n(l1.cs_n), .sck(l1.sck),
    .dev_dq_oe(l1.dev_dq_oe), .PROTECT_I(prot), .BUSY_O(busy), .UNLOCK_O(unl),
    .POWER_DOWN_O(pd), .WIPE_START_O(ws), .WIPE_KIND_O(wk), .WIPE_BASE_O(wb));
  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Erase starts are counted and latched; a hang ends the run
  always @(posedge clk) begin
    cyc++;
    if (ws === 1'b1) begin
      n_ws++;
      last_k = wk;
      last_b = wb;
    end
    if (ws2 === 1'b1) n_ws2++;
    if (cyc == 40000) begin
      fails++;
      print_verdict();
    end
  end
  function automatic logic [23:0] base_of(input logic [7:0] o, input logic [23:0] x);
    case (o)
      8'h20: return {x[23:12], 12'h000};
      8'h52: return {x[23:15], 15'h0000};
      8'hD8: return {x[23:16], 16'h0000};
      default: return 24'h000000;
    endcase
  endfunction
  function automatic fepd_wipe_t kind_of(input logic [7:0] o);
    case (o)
      8'h20: return WIPE_SMALL;
      8'h52: return WIPE_HALF;
      8'hD8: return WIPE_FULL;
      default: return WIPE_ARRAY;
    endcase
  endfunction
  // One host request, raised for one clock once ready, then wait for its completion
  task automatic send(input logic [7:0] o, input logic [23:0] x);
    int k;
    for (k = 0; k < 100 && rdy !== 1'b1; k++) @(posedge clk);
    req <= 1'b1;
    opc <= o;
    adr <= x;
    @(posedge clk);
    req <= 1'b0;
    for (k = 0; k < 600 && done !== 1'b1; k++) @(posedge clk);
    @(posedge clk);
  endtask
  task automatic wipe(input logic [7:0] o, input logic [23:0] x, input int exp_n);
    int n0;
    n0 = n_ws;
    send(8'h06, 24'h000000);
    send(o, x);
    `CHK(n_ws - n0, exp_n, "erase start count")
    if (exp_n == 1) begin
      `CHK(last_k, kind_of(o), "erase kind")
      `CHK(last_b, base_of(o, x), "erase base")
      `CHK(busy, 1'b1, "busy missing")
    end
  endtask
  // Wait out a running erase; unlock must be gone when it ends
  task automatic settle();
    int k;
    for (k = 0; k < 500 && busy !== 1'b0; k++) @(posedge clk);
    `CHK(busy, 1'b0, "busy stuck")
    `CHK(unl, 1'b0, "unlock kept")
  endtask
  task automatic await_pd(input logic v);
    int k;
    for (k = 0; k < 40 && pd !== v; k++) @(posedge clk);
  endtask
  // Bit-level frame on the second link, at 320 ns per serial clock
  task automatic bb(input logic [39:0] v, input int n);
    #7 l2.cs_n = 1'b0;
    l2.host_dq_oe = 4'h1;
    for (int j = 0; j < n; j++) begin
      l2.host_dq_o = {3'h0, v[39-j]};
      #160 l2.sck = 1'b1;
      #160 l2.sck = 1'b0;
    end
    #160 l2.cs_n = 1'b1;
    l2.host_dq_oe = 4'h0;
    repeat (120) @(posedge clk);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    req = 1'b0;
    quad = 1'b0;
    ext = 1'b0;
    prot = 4'h0;
    opc = 8'h00;
    adr = 24'h000000;
    l2.cs_n = 1'b1;
    l2.sck = 1'b0;
    l2.host_dq_o = 4'h0;
    l2.host_dq_oe = 4'h0;
    void'($urandom(77));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    send(8'h20, 24'h012345);
    `CHK(n_ws, 0, "erase without unlock")
    `CHK(pd, 1'b0, "deselect gave power-down")
    tend("no_unlock");
    for (i = 0; i < 5; i++) begin
      a = (i == 0) ? 24'h0FFFFF : (24'($urandom()) & 24'h0FFFFF);
      wipe(ops[i], a, 1);
      settle();
    end
    tend("all_kinds");
    prot <= 4'hF;
    wipe(8'h20, 24'h000000, 0);
    prot <= 4'h1;
    wipe(8'hC7, 24'h000000, 0);
    prot <= 4'h0;
    ext <= 1'b1;
    wipe(8'h52, 24'($urandom()) & 24'h0FFFFF, 0);
    ext <= 1'b0;
    tend("refusals");
    wipe(8'h20, 24'($urandom()) & 24'h0FFFFF, 1);
    send(8'hB9, 24'h000000);
    `CHK(pd, 1'b0, "power-down during erase")
    `CHK(busy, 1'b1, "erase disturbed")
    settle();
    tend("pd_while_busy");
    send(8'hB9, 24'h000000);
    await_pd(1'b1);
    `CHK(pd, 1'b1, "no power-down")
    wipe(8'h20, 24'h001000, 0);
    `CHK(unl, 1'b0, "unlock taken in power-down")
    send(8'hAB, 24'h000000);
    await_pd(1'b0);
    `CHK(pd, 1'b0, "no wake")
    tend("power_down");
    send(8'h38, 24'h000000);
    `CHK(qd, 1'b1, "no four-line mode")
    quad <= 1'b1;
    wipe(8'hD8, 24'($urandom()) & 24'h0FFFFF, 1);
    settle();
    wipe(8'h60, 24'h000000, 1);
    settle();
    send(8'hB9, 24'h000000);
    await_pd(1'b1);
    `CHK(pd, 1'b1, "no power-down in four-line mode")
    tend("four_line");
    nrst <= 1'b0;
    quad <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK(pd, 1'b0, "power-down kept over reset")
    `CHK(qd, 1'b0, "four-line kept over reset")
    wipe(8'h20, 24'($urandom()) & 24'h0FFFFF, 1);
    settle();
    tend("reset_mid_run");
    bb({8'h06, 32'h00000000}, 8);
    `CHK(unl2, 1'b1, "unlock lost")
    bb({8'h20, 24'h003000, 8'h00}, 31);
    `CHK(n_ws2, 0, "short address frame taken")
    bb({8'h20, 24'h003000, 8'h00}, 33);
    `CHK(n_ws2, 0, "long address frame taken")
    bb({8'hC7, 32'h00000000}, 9);
    `CHK(n_ws2, 0, "long opcode frame taken")
    bb({8'hC7, 32'h00000000}, 8);
    `CHK(n_ws2, 1, "exact array frame lost")
    `CHK(wk2, WIPE_ARRAY, "array kind lost")
    `CHK(wb2, 24'h000000, "array base not zero")
    `CHK(busy2, 1'b1, "array cycle not running")
    `CHK({pd2, qd2}, 2'b00, "deselects left standby")
    tend("framing");
    print_verdict();
  end
endmodule // flash_erase_powerdown_ctrl_test
`default_nettype wire
